// file: plcr_pkg.sv
/*
 * Package for the link capability and link control register block:
 * byte offsets, field positions, fixed codes and reset values.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
`default_nettype none

package plcr_pkg;

	// ==========================================================
	// Register map
	localparam logic [11:0] LINK_CAPABILITIES_OFFS = 12'h04c;
	localparam logic [11:0] LINK_CONTROL_OFFS = 12'h050;
	localparam logic [11:0] PLCR_UNLOCK_OFFS = 12'h100;

	// ==========================================================
	// Link capabilities fields
	localparam int MAX_SPEED_LSB = 0;
	localparam int MAX_WIDTH_LSB = 4;
	localparam int LPS_SUPPORT_LSB = 10;
	localparam int L0S_LAT_LSB = 12;
	localparam int L1_LAT_LSB = 15;
	localparam int REFCLK_RM_BIT = 18;
	localparam int SURPRISE_BIT = 19;
	localparam int LINK_ACTIVE_BIT = 20;
	localparam int PORT_INDEX_LSB = 24;

	localparam logic [3:0] MAX_SPEED_GEN1 = 4'h1;
	localparam logic [5:0] WIDTH_X1 = 6'h01;
	localparam logic [5:0] WIDTH_X2 = 6'h02;
	localparam logic [5:0] WIDTH_X4 = 6'h04;
	localparam logic [1:0] LPS_SUPPORT_BOTH = 2'h3;
	localparam logic [2:0] L0S_LAT_SEPARATE = 3'h5;
	localparam logic [2:0] L0S_LAT_COMMON = 3'h3;
	localparam logic [2:0] L1_LAT_RESET = 3'h2;
	localparam logic REFCLK_RM_RESET = 1'h0;
	localparam logic DOWNSTREAM_CAP_RESET = 1'h1;

	// ==========================================================
	// Link control fields
	localparam int LPE_CTRL_LSB = 0;
	localparam int COMPL_BOUND_BIT = 3;
	localparam int SHARED_REFCLK_BIT = 6;
	localparam logic [1:0] LPE_CTRL_RESET = 2'h0;
	localparam logic [1:0] LPE_L0S = 2'h1;
	localparam logic [1:0] LPE_L1 = 2'h2;
	localparam logic [1:0] LPE_BOTH = 2'h3;

	// Unlock register
	localparam int UNLOCK_BIT = 0;

endpackage

`default_nettype wire

// file: plcr_regs.sv
/*
 * Link capabilities and link control register bank for one switch
 * port, reached over APB. Assumes the EEPROM loader presents one
 * load strobe after reset, and that strap parameters are static.
 */
// The APB slave port is this design's own decision.
`default_nettype none

module plcr_regs
	import plcr_pkg::*;
#(
	parameter logic [5:0] LANE_WIDTH = 6'h04,
	parameter logic IS_UPSTREAM = 1'b1,
	parameter logic [7:0] PORT_NUMBER = 8'h00
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// EEPROM preload
	input wire logic eeprom_load,
	input wire logic [1:0] eeprom_lpe_ctrl,
	// Link-facing controls
	output logic [5:0] effective_width,
	output logic [1:0] lowpower_entry_control,
	output logic shared_refclk_flag
);
	import plcr_pkg::*;

	// ==========================================================
	// State
	logic [5:0] max_width_cap;
	logic [2:0] l1_exit_latency;
	logic refclk_removal_cap;
	logic surprise_down_report_cap;
	logic link_active_report_cap;
	logic unlock;
	logic [31:0] cap_word;
	logic [31:0] ctl_word;
	logic [2:0] l0s_exit_latency;
	logic wr_cap;
	logic wr_ctl;
	logic wr_unlock;
	logic access;
	logic mapped;

	plcr_width_if wif ();

	plcr_width_dec u_width_dec (
		.wif(wif.decoder)
	);

	assign wif.programmed = max_width_cap;
	assign effective_width = wif.effective;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] offs);
		return a == offs;
	endfunction

	// ==========================================================
	// Bus decode; zero wait states, unmapped reads zero with error
	assign access = psel && penable;
	assign pready = 1'b1;
	assign mapped = hit(paddr, LINK_CAPABILITIES_OFFS) || hit(paddr, LINK_CONTROL_OFFS)
		|| hit(paddr, PLCR_UNLOCK_OFFS);
	assign pslverr = access && !mapped;
	assign wr_cap = access && pwrite && hit(paddr, LINK_CAPABILITIES_OFFS);
	assign wr_ctl = access && pwrite && hit(paddr, LINK_CONTROL_OFFS);
	assign wr_unlock = access && pwrite && hit(paddr, PLCR_UNLOCK_OFFS);

	// ==========================================================
	// Unlock control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unlock <= 1'b0;
		end else if (wr_unlock && pstrb[0]) begin
			unlock <= pwdata[UNLOCK_BIT];
		end
	end

	// ==========================================================
	// Lockable capability fields
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			max_width_cap <= LANE_WIDTH;
			l1_exit_latency <= L1_LAT_RESET;
			refclk_removal_cap <= REFCLK_RM_RESET;
			surprise_down_report_cap <= IS_UPSTREAM ? 1'b0 : DOWNSTREAM_CAP_RESET;
			link_active_report_cap <= IS_UPSTREAM ? 1'b0 : DOWNSTREAM_CAP_RESET;
		end else if (wr_cap && unlock) begin
			// Downstream width is fixed by its lanes; only upstream narrows
			if (IS_UPSTREAM && pstrb[0] && pstrb[1]) begin
				max_width_cap <= pwdata[MAX_WIDTH_LSB +: 6];
			end
			if (pstrb[1]) begin
				l1_exit_latency[0] <= pwdata[L1_LAT_LSB];
			end
			if (pstrb[2]) begin
				l1_exit_latency[2:1] <= pwdata[L1_LAT_LSB + 1 +: 2];
				refclk_removal_cap <= pwdata[REFCLK_RM_BIT];
				// Not applicable upstream, kept zero there
				surprise_down_report_cap <= pwdata[SURPRISE_BIT] && !IS_UPSTREAM;
				link_active_report_cap <= pwdata[LINK_ACTIVE_BIT] && !IS_UPSTREAM;
			end
		end
	end

	// ==========================================================
	// Link control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lowpower_entry_control <= LPE_CTRL_RESET;
			shared_refclk_flag <= 1'b0;
		end else if (eeprom_load) begin
			lowpower_entry_control <= eeprom_lpe_ctrl;
		end else if (wr_ctl && pstrb[0]) begin
			lowpower_entry_control <= pwdata[LPE_CTRL_LSB +: 2];
			shared_refclk_flag <= pwdata[SHARED_REFCLK_BIT];
		end
	end

	// ==========================================================
	// Read words
	assign l0s_exit_latency = shared_refclk_flag ? L0S_LAT_COMMON : L0S_LAT_SEPARATE;

	always_comb begin
		cap_word = '0;
		cap_word[MAX_SPEED_LSB +: 4] = MAX_SPEED_GEN1;
		cap_word[MAX_WIDTH_LSB +: 6] = max_width_cap;
		cap_word[LPS_SUPPORT_LSB +: 2] = LPS_SUPPORT_BOTH;
		cap_word[L0S_LAT_LSB +: 3] = l0s_exit_latency;
		cap_word[L1_LAT_LSB +: 3] = l1_exit_latency;
		cap_word[REFCLK_RM_BIT] = refclk_removal_cap;
		cap_word[SURPRISE_BIT] = surprise_down_report_cap;
		cap_word[LINK_ACTIVE_BIT] = link_active_report_cap;
		cap_word[PORT_INDEX_LSB +: 8] = PORT_NUMBER;
	end

	always_comb begin
		ctl_word = '0;
		ctl_word[LPE_CTRL_LSB +: 2] = lowpower_entry_control;
		ctl_word[COMPL_BOUND_BIT] = 1'b0;
		ctl_word[SHARED_REFCLK_BIT] = shared_refclk_flag;
	end

	// Registered read data, loaded in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			if (hit(paddr, LINK_CAPABILITIES_OFFS)) begin
				prdata <= cap_word;
			end else if (hit(paddr, LINK_CONTROL_OFFS)) begin
				prdata <= ctl_word;
			end else if (hit(paddr, PLCR_UNLOCK_OFFS)) begin
				prdata <= {31'h0, unlock};
			end else begin
				prdata <= '0;
			end
		end
	end

	// ==========================================================
	// Checks
	a_speed_fixed: assert property (@(posedge pclk) disable iff (!presetn)
		cap_word[3:0] == 4'h1) else $error("max speed not gen1");
	a_support_fixed: assert property (@(posedge pclk) disable iff (!presetn)
		cap_word[11:10] == 2'h3) else $error("support field wrong");
	a_l0s_separate: assert property (@(posedge pclk) disable iff (!presetn)
		!shared_refclk_flag |-> cap_word[14:12] == 3'h5) else $error("l0s sep wrong");
	a_l0s_common: assert property (@(posedge pclk) disable iff (!presetn)
		shared_refclk_flag |-> cap_word[14:12] == 3'h3) else $error("l0s common wrong");
	a_refclk_set: assert property (@(posedge pclk) disable iff (!presetn)
		wr_ctl && pstrb[0] && !eeprom_load |=> shared_refclk_flag == $past(pwdata[6]))
		else $error("flag not written");
	a_port_index: assert property (@(posedge pclk) disable iff (!presetn)
		cap_word[31:24] == PORT_NUMBER) else $error("port index wrong");
	a_eeprom_load: assert property (@(posedge pclk) disable iff (!presetn)
		eeprom_load |=> lowpower_entry_control == $past(eeprom_lpe_ctrl))
		else $error("eeprom value lost");
	a_bound_zero: assert property (@(posedge pclk) disable iff (!presetn)
		ctl_word[3] == 1'b0) else $error("boundary bit set");
	a_lock_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!unlock ##1 1'b1 |-> $stable(l1_exit_latency) && $stable(max_width_cap))
		else $error("locked field changed");
	a_width_valid: assert property (@(posedge pclk) disable iff (!presetn)
		effective_width inside {6'h01, 6'h02, 6'h04}) else $error("bad width");
	a_down_fixed: assert property (@(posedge pclk) disable iff (!presetn)
		!IS_UPSTREAM |-> max_width_cap == LANE_WIDTH) else $error("width moved");
	a_up_zero: assert property (@(posedge pclk) disable iff (!presetn)
		IS_UPSTREAM |-> !cap_word[19] && !cap_word[20]) else $error("upstream cap set");

	// ==========================================================
	// Multi-step checks built from bus phases
	sequence s_cap_upper_write;
		wr_cap && unlock && pstrb[2];
	endsequence

	sequence s_cap_width_write;
		wr_cap && unlock && pstrb[0] && pstrb[1];
	endsequence

	sequence s_ctl_write;
		wr_ctl && pstrb[0] && !eeprom_load;
	endsequence

	sequence s_cap_read_setup;
		psel && !penable && !pwrite && hit(paddr, LINK_CAPABILITIES_OFFS);
	endsequence

	a_l1_written: assert property (@(posedge pclk) disable iff (!presetn)
		s_cap_upper_write |=> l1_exit_latency[2:1] == $past(pwdata[17:16]))
		else $error("l1 latency not written");
	a_width_override: assert property (@(posedge pclk) disable iff (!presetn)
		IS_UPSTREAM ##0 s_cap_width_write |=> max_width_cap == $past(pwdata[9:4]))
		else $error("width override lost");
	a_entry_written: assert property (@(posedge pclk) disable iff (!presetn)
		s_ctl_write |=> lowpower_entry_control == $past(pwdata[1:0]))
		else $error("entry control not written");
	a_ctl_reserved: assert property (@(posedge pclk) disable iff (!presetn)
		ctl_word[31:7] == 25'h0 && ctl_word[5:2] == 4'h0)
		else $error("control reserved bits set");
	a_cap_read: assert property (@(posedge pclk) disable iff (!presetn)
		s_cap_read_setup |=> prdata == $past(cap_word))
		else $error("capability read data wrong");
	a_refclk_rm_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!wr_cap ##1 1'b1 |-> $stable(refclk_removal_cap))
		else $error("refclk removal cap moved");

endmodule

`default_nettype wire

// file: plcr_width_dec.sv
/*
 * Width decoder: maps the programmed maximum width code onto the width
 * the link really trains to. Assumes a purely combinational use.
 */
`default_nettype none

module plcr_width_dec
	import plcr_pkg::*;
(
	// Width codes
	plcr_width_if.decoder wif
);

	// ==========================================================
	// Decode
	always_comb begin
		unique case (wif.programmed)
			WIDTH_X1, WIDTH_X2, WIDTH_X4: wif.effective = wif.programmed;
			default: wif.effective = WIDTH_X1;
		endcase
	end

endmodule

`default_nettype wire

// file: plcr_width_if.sv
/*
 * Interface carrying the programmed width code to the width decoder
 * and the effective width back. Assumes both ends share one clock.
 */
`default_nettype none

interface plcr_width_if;
	logic [5:0] programmed;
	logic [5:0] effective;
	modport owner (output programmed, input effective);
	modport decoder (input programmed, output effective);
endinterface

`default_nettype wire

// file: tb_top.sv
/*
 * Self-checking bench for the link capability and control register bank.
 * Assumes zero-wait APB with pready high and an upstream x4 port 0.
 */
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import plcr_pkg::*;

	// ==========================================================
	// Signals and model state
	localparam logic [11:0] CAP = LINK_CAPABILITIES_OFFS;
	localparam logic [11:0] CTL = LINK_CONTROL_OFFS;
	localparam logic [11:0] UNL = PLCR_UNLOCK_OFFS;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic eeprom_load = 1'b0;
	logic [1:0] eeprom_lpe_ctrl = 2'h0;
	logic [31:0] prdata, rd, d;
	logic pready, pslverr, shared_refclk_flag, err, rm, shared;
	logic [1:0] lowpower_entry_control, lpe;
	logic [5:0] effective_width, width;
	logic [2:0] l1;
	integer seed = 32'hd057;
	integer miscompares = 0;
	integer checked = 0;
	integer i;

	always #50 pclk = ~pclk;

	plcr_regs #(.LANE_WIDTH(6'h04), .IS_UPSTREAM(1'b1), .PORT_NUMBER(8'h00)) i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.eeprom_load(eeprom_load), .eeprom_lpe_ctrl(eeprom_lpe_ctrl),
		.effective_width(effective_width),
		.lowpower_entry_control(lowpower_entry_control),
		.shared_refclk_flag(shared_refclk_flag)
	);

	// ==========================================================
	// Model, bus and compare tasks
	function automatic logic [31:0] cap_exp();
		return {8'h00, 5'h00, rm, l1, shared ? 3'h3 : 3'h5, 2'h3, width, 4'h1};
	endfunction

	// Reserved codes fall back to a single lane
	function automatic logic [5:0] eff(input logic [5:0] w);
		return (w == 6'h01 || w == 6'h02 || w == 6'h04) ? w : 6'h01;
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic reset_model();
		width = 6'h04;
		l1 = 3'h2;
		rm = 1'b0;
		shared = 1'b0;
		lpe = 2'h0;
	endtask

	task complete_run;
		$display("miscompares=%0d checked=%0d", miscompares, checked);
		if (miscompares == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		reset_model();
		apb(1'b0, CAP, 32'h0);
		chk(rd, cap_exp());
		apb(1'b0, CTL, 32'h0);
		chk(rd, 32'h0);
		chk({26'h0, effective_width}, {26'h0, width});
		// Locked: capability writes must bounce
		apb(1'b1, CAP, $random(seed));
		apb(1'b0, CAP, 32'h0);
		chk(rd, cap_exp());
		apb(1'b1, UNL, 32'h1);
		apb(1'b0, UNL, 32'h0);
		chk(rd, 32'h1);
		for (i = 0; i < 12; i++) begin
			d = $random(seed);
			if (i < 9)
				d[9:4] = i[5:0];
			apb(1'b1, CAP, d);
			width = d[9:4];
			l1 = d[17:15];
			rm = d[18];
			apb(1'b0, CAP, 32'h0);
			chk(rd, cap_exp());
			chk({26'h0, effective_width}, {26'h0, eff(width)});
		end
		// Every entry code, shared clock both ways, boundary bit forced
		for (i = 0; i < 8; i++) begin
			d = ($random(seed) & 32'h4b) | 32'h8;
			d[1:0] = i[1:0];
			d[6] = i[2];
			apb(1'b1, CTL, d);
			lpe = d[1:0];
			shared = d[6];
			apb(1'b0, CTL, 32'h0);
			chk(rd, {25'h0, shared, 4'h0, lpe});
			chk({29'h0, shared_refclk_flag, lowpower_entry_control}, {29'h0, shared, lpe});
			apb(1'b0, CAP, 32'h0);
			chk(rd, cap_exp());
		end
		lpe = ~lpe;
		@(posedge pclk);
		eeprom_load <= 1'b1;
		eeprom_lpe_ctrl <= lpe;
		@(posedge pclk);
		eeprom_load <= 1'b0;
		apb(1'b0, CTL, 32'h0);
		chk(rd, {25'h0, shared, 4'h0, lpe});
		apb(1'b1, 12'h0f0, 32'hffff_ffff);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, 12'h0f0, 32'h0);
		chk({rd[31:1], err}, 32'h1);
		// Mid-run reset restores defaults
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		reset_model();
		apb(1'b0, CAP, 32'h0);
		chk(rd, cap_exp());
		apb(1'b0, CTL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, UNL, 32'h0);
		chk(rd, 32'h0);
		complete_run;
	end

	initial begin
		repeat (5000) @(posedge pclk);
		miscompares++;
		complete_run;
	end
endmodule

`default_nettype wire
